// ==== shs_pkg.sv ====
// constants, states and carriers for the homing sequencer
// assumes one control-cycle clock shared by all users of the package
package shs_pkg;
  // ==========================================
  // object indices and sub-indices
  localparam logic [15:0] IDX_CTRL  = 16'h6040;
  localparam logic [15:0] IDX_STAT  = 16'h6041;
  localparam logic [15:0] IDX_MODE  = 16'h6060;
  localparam logic [15:0] IDX_MDSP  = 16'h6061;
  localparam logic [15:0] IDX_POS   = 16'h6064;
  localparam logic [15:0] IDX_OFFS  = 16'h607C;
  localparam logic [15:0] IDX_METH  = 16'h6098;
  localparam logic [15:0] IDX_SPEED = 16'h6099;
  localparam logic [15:0] IDX_CALC  = 16'h60E6;
  localparam logic [7:0]  SUB_HI    = 8'h01;
  localparam logic [7:0]  SUB_LO    = 8'h02;
  // ==========================================
  // field positions
  localparam int CW_EN_MSB = 3;
  localparam int CW_HOME   = 4;
  localparam int SW_ARRIVE = 10;
  localparam int SW_FOLLOW = 12;
  localparam int SW_FERR   = 13;
  localparam int SW_HDONE  = 15;
  // ==========================================
  // encodings and reset values
  localparam logic [7:0]  MODE_HM  = 8'h06;
  localparam logic [7:0]  CALC_ABS = 8'h00;
  localparam logic [7:0]  CALC_REL = 8'h01;
  localparam logic [7:0]  METH_1   = 8'h01;
  localparam logic [7:0]  METH_2   = 8'h02;
  localparam logic [7:0]  METH_3   = 8'h03;
  localparam logic [7:0]  METH_4   = 8'h04;
  localparam logic [7:0]  METH_5   = 8'h05;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  CALC_RST = 8'h00;
  localparam logic [7:0]  METH_RST = 8'h01;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  // ==========================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FAST = 3'h1,
    ST_SLOW = 3'h3,
    ST_ARM  = 3'h2,
    ST_STOP = 3'h6,
    ST_DONE = 3'h7
  } shs_state_e;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub;
    logic        wr;
    logic [31:0] wdata;
  } shs_obj_req_s;

  // bit order rev, fwd, home, index matches the filter vectors
  typedef struct packed {
    logic rev_limit;
    logic forward_limit_switch;
    logic home_switch;
    logic index_pulse;
  } shs_sw_s;

  typedef struct packed {
    logic        en;
    logic        fwd;
    logic [31:0] speed;
  } shs_motion_s;

  typedef struct packed {
    shs_state_e  st;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  flt;
    logic [15:0] ctrl;
    logic        hb;
    logic [7:0]  mode;
    logic [7:0]  calc;
    logic [7:0]  meth;
    logic [31:0] spd_hi;
    logic [31:0] spd_lo;
    logic [31:0] offs;
    logic [31:0] pos;
    logic        lvl;
    logic        dir;
    logic        done;
    logic        ferr;
    shs_motion_s mot;
    logic [31:0] rdata;
  } shs_regs_s;
endpackage

// ==== shs_homing.sv ====
// homing sequencer: object access, switch filtering, search state machine
// assumes switch and index inputs are asynchronous pins, delta is on clk_i
`timescale 1ns/10ps
// Notes on behaviour
// - control bits 0..3 all set enable motion
// - bit 4 rise starts, fall ends homing
// - status bits 10,12,13,15 report homing
// - final stop position becomes mechanical origin
// - absolute mode loads feedback with offset
// - relative mode adds offset to feedback
// - high and low speeds from 6099 sub-indices
// - method 1 clear: fast reverse, slow forward
// - method 1 set: slow forward immediately
// - method 2 clear: fast forward, slow reverse
// - method 2 set: slow reverse immediately
// - method 3 clear: fast forward, slow reverse
// - method 3 set: slow reverse immediately
// - method 4 clear: slow forward, rise arms
// - method 4 set: fast reverse, slow forward
// - method 5 clear: fast reverse, slow forward
// - method 5 set: slow forward immediately
// - no mode change while homing runs
module shs_homing (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // object dictionary access
  input  wire shs_pkg::shs_obj_req_s obj_i,
  output logic [31:0]               obj_rdata_o,
  // switches and encoder
  input  wire shs_pkg::shs_sw_s     sw_i,
  input  wire logic [31:0]          pos_delta_i,
  // motion command
  output shs_pkg::shs_motion_s      motion_o
);
  // ==========================================
  // state
  shs_pkg::shs_regs_s q;
  shs_pkg::shs_regs_s d;
  logic [3:0]         nflt;
  logic [3:0]         rise;
  logic [3:0]         fall;
  logic               enabled;
  logic               active;
  logic               start;
  logic               meth_ok;
  logic               fast_fwd;
  logic               sel_rise;
  logic               sel_fall;
  logic               sel_lvl;
  logic               hit;
  logic [15:0]        stat_w;

  assign enabled = &q.ctrl[shs_pkg::CW_EN_MSB:0];
  assign active  = (q.st != shs_pkg::ST_IDLE) && (q.st != shs_pkg::ST_DONE);
  assign start   = enabled && (q.mode == shs_pkg::MODE_HM) && !active
                   && q.ctrl[shs_pkg::CW_HOME] && !q.hb;
  assign meth_ok = (q.meth >= shs_pkg::METH_1) && (q.meth <= shs_pkg::METH_5);
  assign fast_fwd = (q.meth == shs_pkg::METH_2) || (q.meth == shs_pkg::METH_3);
  assign hit     = q.lvl ? sel_rise : sel_fall;

  always_comb begin
    stat_w = 16'h0000;
    stat_w[shs_pkg::SW_ARRIVE] = q.done;
    stat_w[shs_pkg::SW_FOLLOW] = active;
    stat_w[shs_pkg::SW_FERR]   = q.ferr;
    stat_w[shs_pkg::SW_HDONE]  = q.done;
  end

  // ==========================================
  // filter: a change counts once stages two and three agree
  always_comb begin
    nflt = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.flt);
    rise = nflt & ~q.flt;
    fall = ~nflt & q.flt;
    case (q.meth)
      shs_pkg::METH_1: begin
        sel_rise = rise[3];
        sel_fall = fall[3];
        sel_lvl  = nflt[3];
      end
      shs_pkg::METH_2: begin
        sel_rise = rise[2];
        sel_fall = fall[2];
        sel_lvl  = nflt[2];
      end
      default: begin
        sel_rise = rise[1];
        sel_fall = fall[1];
        sel_lvl  = nflt[1];
      end
    endcase
  end

  // ==========================================
  // next state
  always_comb begin
    d       = q;
    d.s1    = sw_i;
    d.s2    = q.s1;
    d.s3    = q.s2;
    d.flt   = nflt;
    d.hb    = q.ctrl[shs_pkg::CW_HOME];
    d.pos   = q.pos + pos_delta_i;
    d.rdata = 32'h00000000;
    // object access; a read answers one cycle later
    case (obj_i.index)
      shs_pkg::IDX_CTRL:  d.rdata = {16'h0000, q.ctrl};
      shs_pkg::IDX_STAT:  d.rdata = {16'h0000, stat_w};
      shs_pkg::IDX_MODE:  d.rdata = {24'h000000, q.mode};
      shs_pkg::IDX_MDSP:  d.rdata = {24'h000000, q.mode};
      shs_pkg::IDX_POS:   d.rdata = q.pos;
      shs_pkg::IDX_OFFS:  d.rdata = q.offs;
      shs_pkg::IDX_METH:  d.rdata = {24'h000000, q.meth};
      shs_pkg::IDX_CALC:  d.rdata = {24'h000000, q.calc};
      shs_pkg::IDX_SPEED: d.rdata = (obj_i.sub == shs_pkg::SUB_HI) ? q.spd_hi :
                                    (obj_i.sub == shs_pkg::SUB_LO) ? q.spd_lo : 32'h00000000;
      default:            d.rdata = 32'h00000000;
    endcase
    if (obj_i.wr) begin
      case (obj_i.index)
        shs_pkg::IDX_CTRL: d.ctrl = obj_i.wdata[15:0];
        shs_pkg::IDX_MODE: if (!active) d.mode = obj_i.wdata[7:0];
        shs_pkg::IDX_METH: if (!active) d.meth = obj_i.wdata[7:0];
        shs_pkg::IDX_CALC: d.calc = obj_i.wdata[7:0];
        shs_pkg::IDX_OFFS: d.offs = obj_i.wdata;
        shs_pkg::IDX_SPEED: begin
          if (obj_i.sub == shs_pkg::SUB_HI) d.spd_hi = obj_i.wdata;
          if (obj_i.sub == shs_pkg::SUB_LO) d.spd_lo = obj_i.wdata;
        end
        default: ;
      endcase
    end
    // sequence; lvl holds the level whose edge ends the current phase
    case (q.st)
      shs_pkg::ST_IDLE, shs_pkg::ST_DONE: begin
        if (q.st == shs_pkg::ST_DONE && !q.ctrl[shs_pkg::CW_HOME])
          d.st = shs_pkg::ST_IDLE;
        if (start) begin
          d.done = 1'b0;
          d.ferr = !meth_ok;
          if (!meth_ok) begin
            d.st = shs_pkg::ST_IDLE;
          end else if (q.meth == shs_pkg::METH_4) begin
            d.st  = sel_lvl ? shs_pkg::ST_FAST : shs_pkg::ST_SLOW;
            d.dir = !sel_lvl;
            d.lvl = !sel_lvl;
          end else if (!sel_lvl) begin
            d.st  = shs_pkg::ST_FAST;
            d.dir = fast_fwd;
            d.lvl = 1'b1;
          end else begin
            d.st  = shs_pkg::ST_SLOW;
            d.dir = !fast_fwd;
            d.lvl = 1'b0;
          end
        end
      end
      shs_pkg::ST_FAST: if (hit) begin
        d.st  = shs_pkg::ST_SLOW;
        d.dir = !q.dir;
        d.lvl = !q.lvl;
      end
      shs_pkg::ST_SLOW: if (hit) d.st = shs_pkg::ST_ARM;
      shs_pkg::ST_ARM:  if (rise[0]) d.st = shs_pkg::ST_STOP;
      shs_pkg::ST_STOP: begin
        // motion is already off here, so this is the resting point
        d.pos  = (q.calc == shs_pkg::CALC_REL) ? q.pos + q.offs : q.offs;
        d.st   = shs_pkg::ST_DONE;
        d.done = 1'b1;
      end
      default: d.st = shs_pkg::ST_IDLE;
    endcase
    // abort on early clear of bit 4 or loss of enable
    if (active && (!q.ctrl[shs_pkg::CW_HOME] || !enabled)) begin
      d.st   = shs_pkg::ST_IDLE;
      d.done = 1'b0;
    end
    d.mot.en    = (d.st == shs_pkg::ST_FAST) || (d.st == shs_pkg::ST_SLOW)
                  || (d.st == shs_pkg::ST_ARM);
    d.mot.fwd   = d.dir;
    d.mot.speed = (d.st == shs_pkg::ST_FAST) ? q.spd_hi :
                  d.mot.en ? q.spd_lo : 32'h00000000;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.st     <= shs_pkg::ST_IDLE;
      q.ctrl   <= shs_pkg::CTRL_RST;
      q.mode   <= shs_pkg::MODE_RST;
      q.calc   <= shs_pkg::CALC_RST;
      q.meth   <= shs_pkg::METH_RST;
      q.spd_hi <= shs_pkg::WORD_RST;
      q.spd_lo <= shs_pkg::WORD_RST;
      q.offs   <= shs_pkg::WORD_RST;
      q.pos    <= shs_pkg::WORD_RST;
    end else begin
      q <= d;
    end
  end

  assign obj_rdata_o = q.rdata;
  assign motion_o    = q.mot;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_en_needs_ctrl;
    motion_o.en |-> $past(enabled);
  endproperty
  a_en_needs_ctrl: assert property (p_en_needs_ctrl) else $error("motion without enable");

  property p_start;
    (start && meth_ok) |=> (q.st != shs_pkg::ST_IDLE) && motion_o.en;
  endproperty
  a_start: assert property (p_start) else $error("homing did not start");

  property p_status;
    (q.st == shs_pkg::ST_DONE) |-> stat_w[shs_pkg::SW_HDONE] && stat_w[shs_pkg::SW_ARRIVE]
                                   && !stat_w[shs_pkg::SW_FOLLOW];
  endproperty
  a_status: assert property (p_status) else $error("status word wrong at completion");

  property p_abs_load;
    (q.st == shs_pkg::ST_STOP && q.calc == shs_pkg::CALC_ABS) |=> q.pos == $past(q.offs);
  endproperty
  a_abs_load: assert property (p_abs_load) else $error("absolute reload wrong");

  property p_rel_add;
    (q.st == shs_pkg::ST_STOP && q.calc == shs_pkg::CALC_REL)
      |=> q.pos == $past(q.pos) + $past(q.offs);
  endproperty
  a_rel_add: assert property (p_rel_add) else $error("relative reload wrong");

  property p_fast_speed;
    (q.st == shs_pkg::ST_FAST) |-> motion_o.speed == $past(q.spd_hi);
  endproperty
  a_fast_speed: assert property (p_fast_speed) else $error("fast phase speed wrong");

  property p_index_stop;
    (q.st == shs_pkg::ST_ARM && rise[0] && q.ctrl[shs_pkg::CW_HOME] && enabled)
      |=> (q.st == shs_pkg::ST_STOP) && !motion_o.en;
  endproperty
  a_index_stop: assert property (p_index_stop) else $error("no stop on index");

  property p_mode_lock;
    (active && obj_i.wr && obj_i.index == shs_pkg::IDX_MODE) |=> $stable(q.mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while homing");

  property p_abort;
    (active && !q.ctrl[shs_pkg::CW_HOME]) |=> (q.st == shs_pkg::ST_IDLE) && !q.done
                                             && !motion_o.en;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");

  // an abort landing in the stop cycle skips completion on purpose
  sequence s_stopped;
    (q.st == shs_pkg::ST_STOP) && !motion_o.en && q.ctrl[shs_pkg::CW_HOME] && enabled;
  endsequence
  sequence s_completed;
    (q.st == shs_pkg::ST_DONE) && q.done;
  endsequence
  property p_done_after_stop;
    $rose(q.done) |-> $past(q.st == shs_pkg::ST_STOP);
  endproperty
  a_done_after_stop: assert property (p_done_after_stop) else $error("done before stop");

  property p_stop_then_done;
    s_stopped |=> s_completed;
  endproperty
  a_stop_then_done: assert property (p_stop_then_done) else $error("stop not followed by done");

  // start direction and speed per method; method 4 turns on the home level
  property p_direct_slow;
    (start && meth_ok && q.meth != shs_pkg::METH_4 && sel_lvl)
      |=> (q.st == shs_pkg::ST_SLOW) && motion_o.en && motion_o.speed == $past(q.spd_lo);
  endproperty
  a_direct_slow: assert property (p_direct_slow) else $error("slow start");

  property p_fast_fwd;
    (start && !sel_lvl && (q.meth == shs_pkg::METH_2 || q.meth == shs_pkg::METH_3))
      |=> (q.st == shs_pkg::ST_FAST) && motion_o.fwd;
  endproperty
  a_fast_fwd: assert property (p_fast_fwd) else $error("fast search not forward");

  property p_fast_rev;
    (start && !sel_lvl && (q.meth == shs_pkg::METH_1 || q.meth == shs_pkg::METH_5))
      |=> (q.st == shs_pkg::ST_FAST) && !motion_o.fwd;
  endproperty
  a_fast_rev: assert property (p_fast_rev) else $error("fast search not reverse");

  property p_m4_start;
    (start && q.meth == shs_pkg::METH_4)
      |=> motion_o.en && (motion_o.fwd != $past(sel_lvl));
  endproperty
  a_m4_start: assert property (p_m4_start) else $error("method 4 direction");

  property p_turn;
    (q.st == shs_pkg::ST_FAST && hit && q.ctrl[shs_pkg::CW_HOME] && enabled)
      |=> (q.st == shs_pkg::ST_SLOW) && (motion_o.fwd != $past(motion_o.fwd))
          && motion_o.speed == $past(q.spd_lo);
  endproperty
  a_turn: assert property (p_turn) else $error("no slow turn");

  // a filtered index edge needs stages two and three to agree first
  property p_idx_filt;
    $rose(q.flt[0]) |-> $past(q.s2[0]) && $past(q.s3[0]);
  endproperty
  a_idx_filt: assert property (p_idx_filt) else $error("index not filtered");

endmodule // shs_homing

// ==== shs_master.sv ====
// fieldbus master model: object writes and reads toward the sequencer
// assumes requests are taken on the rising edge of clk_i
`timescale 1ns/10ps
module shs_master (
  // clock
  input  wire logic             clk_i,
  // object access
  output shs_pkg::shs_obj_req_s obj_o,
  input  wire logic [31:0]      rdata_i
);
  // ==========================================
  // bus tasks
  initial obj_o = '0;

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    obj_o = '{index: idx, sub: sub, wr: 1'b1, wdata: d};
    @(posedge clk_i);
    #1;
    obj_o.wr = 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the index
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, output logic [31:0] d);
    @(posedge clk_i);
    #1;
    obj_o.index = idx;
    obj_o.sub   = sub;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask

  // bit 4 is always cleared first so that a start is a clean rise
  task automatic run(input logic on);
    wr(shs_pkg::IDX_CTRL, 8'h00, 32'h0000000F);
    if (on) wr(shs_pkg::IDX_CTRL, 8'h00, 32'h0000001F);
  endtask
endmodule // shs_master

// ==== servo_homing_sequencer_test.sv ====
// self-checking bench for the homing sequencer
// assumes the master model drives objects; switches come from here
`timescale 1ns/10ps
module servo_homing_sequencer_test;
  logic                  clk_i;
  logic                  rst_i;
  shs_pkg::shs_obj_req_s obj;
  logic [31:0]           rdata;
  shs_pkg::shs_sw_s      sw;
  shs_pkg::shs_motion_s  mot;
  logic [31:0]           rd_v;
  logic [31:0]           delta;
  int                    n_mismatch;
  int                    total_checks;
  localparam logic [31:0] HI  = 32'h00000400;
  localparam logic [31:0] LO  = 32'h00000040;
  localparam logic [31:0] OFS = 32'h00001234;

  shs_homing shs_homing_inst (.clk_i(clk_i), .rst_i(rst_i), .obj_i(obj), .obj_rdata_o(rdata),
    .sw_i(sw), .pos_delta_i(delta), .motion_o(mot));
  shs_master shs_master_inst (.clk_i(clk_i), .obj_o(obj), .rdata_i(rdata));

  // ==========================================
  // helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic w(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    shs_master_inst.wr(idx, sub, d);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] exp);
    shs_master_inst.rd(idx, 8'h00, rd_v);
    chk(rd_v & m, exp);
  endtask

  // switch filtering delays phase changes, so motion is polled with a bound
  task automatic mot_is(input logic en, input logic fwd, input logic [31:0] spd);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      #1;
      if ({mot.en, mot.fwd & mot.en, mot.speed} === {en, fwd, spd}) break;
    end
    chk({mot.en, mot.fwd & mot.en, mot.speed}, {en, fwd, spd});
    if (i == 20) final_report();
  endtask

  task automatic pin(input int k, input logic v);
    @(posedge clk_i);
    #1;
    sw[k] = v;
  endtask

  task automatic zpulse;
    pin(0, 1'b1);
    repeat (6) @(posedge clk_i);
    pin(0, 1'b0);
  endtask

  // ==========================================
  // scenarios
  task automatic t_meth1;
    rdc(shs_pkg::IDX_CTRL, 32'hFFFF, 32'h0);
    rdc(shs_pkg::IDX_METH, 32'hFF, 32'h1);
    w(shs_pkg::IDX_STAT, 8'h00, 32'h0000FFFF);
    rdc(shs_pkg::IDX_STAT, 32'hB400, 32'h0);
    w(shs_pkg::IDX_MODE, 8'h00, {24'h0, shs_pkg::MODE_HM});
    w(shs_pkg::IDX_SPEED, shs_pkg::SUB_HI, HI);
    w(shs_pkg::IDX_SPEED, shs_pkg::SUB_LO, LO);
    w(shs_pkg::IDX_OFFS, 8'h00, OFS);
    shs_master_inst.run(1'b1);
    mot_is(1'b1, 1'b0, HI);
    rdc(shs_pkg::IDX_STAT, 32'hB400, 32'h1000);
    w(shs_pkg::IDX_MODE, 8'h00, 32'h00000003);
    w(shs_pkg::IDX_METH, 8'h00, 32'h00000002);
    rdc(shs_pkg::IDX_MODE, 32'hFF, {24'h0, shs_pkg::MODE_HM});
    rdc(shs_pkg::IDX_METH, 32'hFF, 32'h1);
    rdc(shs_pkg::IDX_MDSP, 32'hFF, {24'h0, shs_pkg::MODE_HM});
    pin(3, 1'b1);
    mot_is(1'b1, 1'b1, LO);
    // an index pulse before the limit falls must not stop the motor
    zpulse();
    mot_is(1'b1, 1'b1, LO);
    pin(3, 1'b0);
    repeat (6) @(posedge clk_i);
    zpulse();
    mot_is(1'b0, 1'b0, 32'h0);
    rdc(shs_pkg::IDX_STAT, 32'hB400, 32'h8400);
    rdc(shs_pkg::IDX_POS, 32'hFFFFFFFF, OFS);
    shs_master_inst.run(1'b0);
  endtask

  task automatic t_meth4_rel;
    w(shs_pkg::IDX_CALC, 8'h00, {24'h0, shs_pkg::CALC_REL});
    w(shs_pkg::IDX_METH, 8'h00, {24'h0, shs_pkg::METH_4});
    pin(1, 1'b1);
    repeat (6) @(posedge clk_i);
    // move the feedback by exactly four increments so the relative base is not the offset
    @(posedge clk_i);
    #1;
    delta = 32'h00000010;
    repeat (4) @(posedge clk_i);
    #1;
    delta = 32'h00000000;
    rdc(shs_pkg::IDX_POS, 32'hFFFFFFFF, OFS + 32'h00000040);
    shs_master_inst.run(1'b1);
    mot_is(1'b1, 1'b0, HI);
    rdc(shs_pkg::IDX_STAT, 32'hB400, 32'h1000);
    pin(1, 1'b0);
    mot_is(1'b1, 1'b1, LO);
    pin(1, 1'b1);
    repeat (6) @(posedge clk_i);
    zpulse();
    mot_is(1'b0, 1'b0, 32'h0);
    rdc(shs_pkg::IDX_POS, 32'hFFFFFFFF, OFS + 32'h00000040 + OFS);
    shs_master_inst.run(1'b0);
  endtask

  task automatic t_abort_bad;
    w(shs_pkg::IDX_METH, 8'h00, {24'h0, shs_pkg::METH_2});
    shs_master_inst.run(1'b1);
    mot_is(1'b1, 1'b1, HI);
    shs_master_inst.run(1'b0);
    mot_is(1'b0, 1'b0, 32'h0);
    rdc(shs_pkg::IDX_STAT, 32'hB400, 32'h0);
    w(shs_pkg::IDX_MODE, 8'h00, 32'h00000003);
    rdc(shs_pkg::IDX_MODE, 32'hFF, 32'h3);
    w(shs_pkg::IDX_MODE, 8'h00, {24'h0, shs_pkg::MODE_HM});
    shs_master_inst.run(1'b1);
    mot_is(1'b1, 1'b1, HI);
    // dropping bit 3 while running is a loss of enable
    w(shs_pkg::IDX_CTRL, 8'h00, 32'h00000017);
    mot_is(1'b0, 1'b0, 32'h0);
    w(shs_pkg::IDX_CTRL, 8'h00, 32'h00000007);
    w(shs_pkg::IDX_CTRL, 8'h00, 32'h00000017);
    mot_is(1'b0, 1'b0, 32'h0);
    w(shs_pkg::IDX_METH, 8'h00, 32'h00000007);
    shs_master_inst.run(1'b1);
    rdc(shs_pkg::IDX_STAT, 32'h2000, 32'h2000);
    mot_is(1'b0, 1'b0, 32'h0);
    shs_master_inst.run(1'b0);
  endtask

  // starts that go straight to the slow search, one per method
  task automatic t_direct;
    logic [3:0] pins [5] = '{4'b1000, 4'b0100, 4'b0010, 4'b0000, 4'b0010};
    logic       dirs [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int m = 0; m < 5; m++) begin
      w(shs_pkg::IDX_METH, 8'h00, 32'(m + 1));
      @(posedge clk_i);
      #1;
      sw = pins[m];
      repeat (6) @(posedge clk_i);
      shs_master_inst.run(1'b1);
      mot_is(1'b1, dirs[m], LO);
      shs_master_inst.run(1'b0);
    end
  endtask

  // ==========================================
  // clock, reset and sequence
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    sw = '0;
    delta = 32'h00000000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_meth1();
    t_meth4_rel();
    t_abort_bad();
    t_direct();
    final_report();
  end
endmodule // servo_homing_sequencer_test
